// File: common/sbi_pkg.sv
// Shared constants for the processor system bus interface.
// Assumes both ends and the interface import this package.
package sbi_pkg;
    localparam int AD_W          = 64;          // Multiplexed address/data width
    localparam int CHK_W         = 8;           // Check bits
    localparam int CMD_W         = 9;           // Command bus incl. parity bit
    localparam int CMD_PAR_BIT   = 8;           // Parity over cmd[7:0]
    localparam int CMD_DATA_BIT  = 7;           // 1 = data word, 0 = address
    // Address cycle fields
    localparam int CMD_TYPE_LSB  = 4;           // Transaction type cmd[6:4]
    localparam int CMD_SIZE_LSB  = 0;           // Size cmd[3:0]
    // Data cycle fields
    localparam int CMD_LAST_BIT  = 6;           // Last word marker
    localparam int CMD_STATE_LSB = 4;           // Cache state cmd[5:4]
    localparam int WBUF_DEPTH    = 8;           // One full line of words
    localparam int FIFO_DEPTH    = 8;
    localparam logic [3:0] CFG_RATE_DEFAULT = 4'h1;

    typedef enum logic [2:0] {
        SBI_READ   = 3'h0,
        SBI_WRITE  = 3'h1,
        SBI_INVAL  = 3'h2,
        SBI_UPDATE = 3'h3,
        SBI_SNOOP  = 3'h4,
        SBI_NULL   = 3'h7
    } sbi_type_e;

    typedef enum logic [3:0] {
        SBI_SZ_BYTE  = 4'h0,
        SBI_SZ_HALF  = 4'h1,
        SBI_SZ_TRI   = 4'h2,
        SBI_SZ_WORD  = 4'h3,
        SBI_SZ_DWORD = 4'h7,
        SBI_SZ_BLOCK = 4'h8
    } sbi_size_e;

    typedef enum logic [1:0] {
        SBI_ST_INVALID = 2'h0,
        SBI_ST_SHARED  = 2'h1,
        SBI_ST_CLEAN_X = 2'h2,
        SBI_ST_DIRTY_X = 2'h3
    } sbi_state_e;

    // Even parity over the low eight command bits
    function automatic logic [CMD_W-1:0] sbi_cmd(input logic [7:0] body);
        sbi_cmd = {^body, body};
    endfunction : sbi_cmd
endpackage : sbi_pkg

// File: common/sbi_if.sv
// Bus between processor end and external agent end.
// Shared wires are resolved here from each side's output enables.
`timescale 1ns/10ps
interface sbi_if;
    import sbi_pkg::*;
    logic [AD_W-1:0]  proc_ad_o,  agent_ad_o;
    logic [CHK_W-1:0] proc_chk_o, agent_chk_o;
    logic [CMD_W-1:0] proc_cmd_o, agent_cmd_o;
    logic             proc_oe,    agent_oe;
    logic [AD_W-1:0]  addr_data_bus;
    logic [CHK_W-1:0] addr_data_check_bus;
    logic [CMD_W-1:0] command_bus;
    logic             read_accept_ready;
    logic             write_accept_ready;
    logic             external_bus_request;
    logic             bus_release;
    logic             proc_drive_qualifier;
    logic             agent_drive_qualifier;

    // Wire level: processor drives if enabled, else agent if enabled, otherwise idle zero
    assign addr_data_bus       = proc_oe ? proc_ad_o  : agent_oe ? agent_ad_o  : '0;
    assign addr_data_check_bus = proc_oe ? proc_chk_o : agent_oe ? agent_chk_o : '0;
    assign command_bus         = proc_oe ? proc_cmd_o : agent_oe ? agent_cmd_o : '0;

    modport proc (
        output proc_ad_o, proc_chk_o, proc_cmd_o, proc_oe,
        output bus_release, proc_drive_qualifier,
        input  addr_data_bus, addr_data_check_bus, command_bus,
        input  read_accept_ready, write_accept_ready,
        input  external_bus_request, agent_drive_qualifier
    );
    modport agent (
        output agent_ad_o, agent_chk_o, agent_cmd_o, agent_oe,
        output read_accept_ready, write_accept_ready,
        output external_bus_request, agent_drive_qualifier,
        input  addr_data_bus, addr_data_check_bus, command_bus,
        input  bus_release, proc_drive_qualifier
    );
endinterface : sbi_if

// File: core/sbi_fifo.sv
// Small valid/ready FIFO in flip-flops.
// Assumes one clock; both sides may stall.
`timescale 1ns/10ps
module sbi_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  empty
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("sbi_fifo: DEPTH must be a power of two, at least 2");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;
    wire              full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);

    // Honest flags from extra pointer bit
    assign empty     = (wr_ptr == rd_ptr);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop)  rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // Storage has no reset; empty flag guards reads
    always_ff @(posedge clock) begin
        if (push) mem[wr_ptr[AW-1:0]] <= in_data;
    end
endmodule : sbi_fifo

// File: core/sbi_proc_end.sv
// Processor end of the multiplexed system bus.
// Assumes the agent keeps its handshake duties; one 40 MHz clock.
`timescale 1ns/10ps
module sbi_proc_end
    import sbi_pkg::*;
#(
    parameter int WORDS = WBUF_DEPTH
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // Boot configuration, caught at reset release
    input  wire logic [3:0]        cfg_rate,
    input  wire logic              cfg_ecc,
    // Core request
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic [2:0]        req_type,
    input  wire logic [3:0]        req_size,
    input  wire logic [AD_W-1:0]   req_addr,
    // Write-back data into line buffer
    input  wire logic              wdata_valid,
    output logic                   wdata_ready,
    input  wire logic [AD_W-1:0]   wdata,
    // Inbound words toward the core
    output logic                   rdata_valid,
    output logic      [AD_W-1:0]   rdata,
    output logic                   rdata_last,
    output logic      [1:0]        rdata_state,
    output logic                   rdata_err,
    // Inbound agent request toward the core
    output logic                   ext_cmd_valid,
    output logic      [CMD_W-1:0]  ext_cmd,
    output logic      [AD_W-1:0]   ext_addr,
    // Bus
    sbi_if.proc                    bus
);
    initial begin
        if (WORDS < 2 || WORDS > FIFO_DEPTH)
            $error("sbi_proc_end: WORDS must be 2..FIFO_DEPTH");
    end

    typedef enum logic [2:0] {
        SBI_P_IDLE = 3'b000,
        SBI_P_ADDR = 3'b001,
        SBI_P_DATA = 3'b011,
        SBI_P_WAIT = 3'b010,
        SBI_P_SLV  = 3'b110
    } sbi_pstate_e;

    sbi_pstate_e      state, next_state;
    logic [3:0]       rate;
    logic             ecc_mode;
    logic             cfg_taken;
    logic [3:0]       pace_cnt;
    logic [2:0]       cur_type;
    logic [3:0]       cur_size;
    logic [AD_W-1:0]  cur_addr;
    logic [3:0]       sent;
    logic             was_ext;

    // Boot bits caught by the first clocked edge after reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_taken <= 1'b0;
            rate      <= CFG_RATE_DEFAULT;
            ecc_mode  <= 1'b0;
        end else if (!cfg_taken) begin
            cfg_taken <= 1'b1;
            rate      <= (cfg_rate == 4'h0) ? CFG_RATE_DEFAULT : cfg_rate;
            ecc_mode  <= cfg_ecc;
        end
    end

    // Outbound pacing enable: one pulse every rate cycles
    wire pace = (pace_cnt == 4'h0);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) pace_cnt <= 4'h0;
        else     pace_cnt <= pace ? rate - 4'h1 : pace_cnt - 4'h1;
    end

    // Write-back line buffer lets the core move on
    logic            wb_valid;
    logic            wb_pop;
    logic [AD_W-1:0] wb_data;
    logic            wb_empty;
    sbi_fifo #(.WIDTH(AD_W), .DEPTH(FIFO_DEPTH)) u_wbuf (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (wdata_valid),
        .in_ready  (wdata_ready),
        .in_data   (wdata),
        .out_valid (wb_valid),
        .out_ready (wb_pop),
        .out_data  (wb_data),
        .empty     (wb_empty)
    );

    // Decode of inbound command
    wire [CMD_W-1:0] in_cmd    = bus.command_bus;
    wire             in_data_w = in_cmd[CMD_DATA_BIT];
    wire             in_par_ok = (^in_cmd[7:0]) == in_cmd[CMD_PAR_BIT];
    wire             in_word   = bus.agent_drive_qualifier && state == SBI_P_SLV;
    wire             is_write  = cur_type == SBI_WRITE || cur_type == SBI_UPDATE;
    wire             is_block  = cur_size == SBI_SZ_BLOCK;
    wire [3:0]       nwords    = is_block ? 4'(WORDS) : 4'h1;
    wire             last_word = (sent == nwords - 4'h1);
    wire             accept    = (cur_type == SBI_READ) ? bus.read_accept_ready
                                                        : bus.write_accept_ready;
    wire             ext_take  = bus.external_bus_request && state == SBI_P_IDLE;

    // Outbound command words
    wire [7:0] addr_body = {1'b0, cur_type, cur_size};
    wire [7:0] data_body = {1'b1, last_word, SBI_ST_DIRTY_X, 4'h0};

    // Main sequencer
    always_comb begin
        next_state = state;
        case (state)
            SBI_P_IDLE: begin
                if (bus.external_bus_request)      next_state = SBI_P_SLV;
                else if (req_valid)                next_state = SBI_P_ADDR;
            end
            SBI_P_ADDR: begin
                if (pace && accept)
                    next_state = is_write ? SBI_P_DATA : SBI_P_WAIT;
            end
            SBI_P_DATA: begin
                if (pace && wb_valid && last_word) next_state = SBI_P_IDLE;
            end
            SBI_P_WAIT:                            next_state = SBI_P_SLV;
            SBI_P_SLV: begin
                if (in_word && in_data_w && in_cmd[CMD_LAST_BIT] && !was_ext)
                    next_state = SBI_P_IDLE;
                else if (was_ext && !bus.external_bus_request)
                    next_state = SBI_P_IDLE;
            end
            default:                               next_state = SBI_P_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state    <= SBI_P_IDLE;
            cur_type <= 3'h0;
            cur_size <= 4'h0;
            cur_addr <= '0;
            sent     <= 4'h0;
            was_ext  <= 1'b0;
        end else begin
            state <= next_state;
            if (state == SBI_P_IDLE && req_valid && !bus.external_bus_request) begin
                cur_type <= req_type;
                cur_size <= req_size;
                cur_addr <= req_addr;
                sent     <= 4'h0;
            end
            if (state == SBI_P_IDLE) was_ext <= ext_take;
            if (wb_pop) sent <= sent + 4'h1;
        end
    end

    assign req_ready = (state == SBI_P_IDLE) && !bus.external_bus_request;
    assign wb_pop    = (state == SBI_P_DATA) && pace && wb_valid;

    // Drivers: the bus is ours outside wait and slave states
    wire drive_addr = (state == SBI_P_ADDR) && pace;
    wire drive_data = (state == SBI_P_DATA) && pace && wb_valid;
    assign bus.proc_oe              = !bus.bus_release;
    assign bus.proc_drive_qualifier = drive_addr || drive_data;
    assign bus.proc_ad_o  = drive_data ? wb_data : drive_addr ? cur_addr : '0;
    assign bus.proc_cmd_o = drive_data ? sbi_cmd(data_body)
                          : drive_addr ? sbi_cmd(addr_body) : '0;
    // Check bits: bytewise parity or a simple fold for ECC mode
    logic [CHK_W-1:0] chk;
    always_comb begin
        for (int i = 0; i < CHK_W; i++)
            chk[i] = ecc_mode ? ^(bus.proc_ad_o & {8{8'h01 << i}})
                              : ^bus.proc_ad_o[i*8 +: 8];
    end
    assign bus.proc_chk_o  = chk;
    assign bus.bus_release = (state == SBI_P_WAIT) || (state == SBI_P_SLV);

    // Inbound capture at the agent's own pace
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_valid   <= 1'b0;
            rdata         <= '0;
            rdata_last    <= 1'b0;
            rdata_state   <= 2'h0;
            rdata_err     <= 1'b0;
            ext_cmd_valid <= 1'b0;
            ext_cmd       <= '0;
            ext_addr      <= '0;
        end else begin
            rdata_valid   <= in_word && in_data_w;
            ext_cmd_valid <= in_word && !in_data_w;
            if (in_word && in_data_w) begin
                rdata       <= bus.addr_data_bus;
                rdata_last  <= in_cmd[CMD_LAST_BIT];
                rdata_state <= in_cmd[CMD_STATE_LSB +: 2];
                rdata_err   <= !in_par_ok;
            end
            if (in_word && !in_data_w) begin
                ext_cmd  <= in_cmd;
                ext_addr <= bus.addr_data_bus;
            end
        end
    end
endmodule : sbi_proc_end

// File: core/sbi_agent_end.sv
// External agent end: simple memory-side responder and requester.
// Assumes the processor end keeps its release and qualifier duties.
`timescale 1ns/10ps
module sbi_agent_end
    import sbi_pkg::*;
#(
    parameter int WORDS = WBUF_DEPTH
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // User acceptance control
    input  wire logic             can_read,
    input  wire logic             can_write,
    // Seen processor requests
    output logic                  preq_valid,
    output logic     [CMD_W-1:0]  preq_cmd,
    output logic     [AD_W-1:0]   preq_addr,
    output logic                  pwdata_valid,
    output logic     [AD_W-1:0]   pwdata,
    // Read reply words to send
    input  wire logic             reply_valid,
    input  wire logic [AD_W-1:0]  reply_data,
    input  wire logic             reply_last,
    // Agent's own request
    input  wire logic             own_req,
    input  wire logic [7:0]       own_cmd,
    input  wire logic [AD_W-1:0]  own_addr,
    output logic                  own_done,
    // Bus
    sbi_if.agent                  bus
);
    initial begin
        if (WORDS < 1) $error("sbi_agent_end: WORDS must be positive");
    end
    typedef enum logic [1:0] {
        SBI_A_IDLE = 2'b00,
        SBI_A_REQ  = 2'b01,
        SBI_A_OWN  = 2'b11
    } sbi_astate_e;
    sbi_astate_e state, next_state;

    wire cmd_data = bus.command_bus[CMD_DATA_BIT];
    wire pv       = bus.proc_drive_qualifier;
    wire own_send = state == SBI_A_OWN && own_req;
    wire rep_send = bus.bus_release && state == SBI_A_IDLE && reply_valid;

    always_comb begin
        next_state = state;
        case (state)
            SBI_A_IDLE: if (own_req && !bus.bus_release) next_state = SBI_A_REQ;
            SBI_A_REQ:  if (bus.bus_release)             next_state = SBI_A_OWN;
            SBI_A_OWN:                                   next_state = SBI_A_IDLE;
            default:                                     next_state = SBI_A_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) state <= SBI_A_IDLE;
        else     state <= next_state;
    end

    assign bus.read_accept_ready    = can_read;
    assign bus.write_accept_ready   = can_write;
    assign bus.external_bus_request = state != SBI_A_IDLE;
    assign bus.agent_oe             = bus.bus_release;
    assign bus.agent_drive_qualifier = own_send || rep_send;
    assign bus.agent_ad_o  = own_send ? own_addr : rep_send ? reply_data : '0;
    assign bus.agent_cmd_o = own_send ? sbi_cmd({1'b0, own_cmd[6:0]})
                           : rep_send ? sbi_cmd({1'b1, reply_last, SBI_ST_CLEAN_X, 4'h0})
                           : '0;
    assign bus.agent_chk_o = '0;
    assign own_done = own_send;

    // Capture what the processor sends
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            preq_valid   <= 1'b0;
            preq_cmd     <= '0;
            preq_addr    <= '0;
            pwdata_valid <= 1'b0;
            pwdata       <= '0;
        end else begin
            preq_valid   <= pv && !cmd_data;
            pwdata_valid <= pv && cmd_data;
            if (pv && !cmd_data) begin
                preq_cmd  <= bus.command_bus;
                preq_addr <= bus.addr_data_bus;
            end
            if (pv && cmd_data) pwdata <= bus.addr_data_bus;
        end
    end
endmodule : sbi_agent_end

// File: tb/sbi_assertions.sv
// Concurrent checks on the shared system bus wires.
// Assumes instantiation beside the interface in the bench top.
`timescale 1ns/10ps
module sbi_assertions
    import sbi_pkg::*;
(
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Bus wires
    input  wire logic             proc_oe,
    input  wire logic             agent_oe,
    input  wire logic [CMD_W-1:0] command_bus,
    input  wire logic             read_accept_ready,
    input  wire logic             external_bus_request,
    input  wire logic             bus_release,
    input  wire logic             proc_drive_qualifier,
    input  wire logic             agent_drive_qualifier
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Read address cycle on the wire
    wire rd_addr = proc_drive_qualifier && !command_bus[CMD_DATA_BIT]
                   && command_bus[6:4] == SBI_READ;

    property p_parity; (proc_drive_qualifier || agent_drive_qualifier)
        |-> command_bus[CMD_PAR_BIT] == ^command_bus[7:0]; endproperty
    a_parity: assert property (p_parity) else $error("bad command parity");
    property p_qual; proc_drive_qualifier |-> proc_oe && !bus_release; endproperty
    a_qual: assert property (p_qual) else $error("qualifier without drive");
    property p_one_drv; !(proc_oe && agent_oe); endproperty
    a_one_drv: assert property (p_one_drv) else $error("both ends drive");
    property p_grant; $rose(external_bus_request) |-> ##[1:64] bus_release; endproperty
    a_grant: assert property (p_grant) else $error("request not granted");
    property p_quiet; bus_release |-> !proc_oe && !proc_drive_qualifier; endproperty
    a_quiet: assert property (p_quiet) else $error("released but driving");
    property p_hold; rd_addr && !read_accept_ready |=> !bus_release; endproperty
    a_hold: assert property (p_hold) else $error("address dropped early");
    property p_rd_rel; rd_addr && read_accept_ready |=> bus_release; endproperty
    a_rd_rel: assert property (p_rd_rel) else $error("no release after read");
    property p_agent; agent_drive_qualifier |-> bus_release && agent_oe; endproperty
    a_agent: assert property (p_agent) else $error("agent drives unowned");
    property p_boot; $fell(rst) |-> proc_oe && !bus_release && !proc_drive_qualifier;
    endproperty
    a_boot: assert property (p_boot) else $error("not idle master");
    // Main traffic kinds
    c_read: cover property (rd_addr && read_accept_ready);
    c_ext: cover property (agent_drive_qualifier && !command_bus[CMD_DATA_BIT]);
    c_wdat: cover property (proc_drive_qualifier && command_bus[CMD_DATA_BIT]);
endmodule : sbi_assertions

// File: tb/processor_system_bus_interface_test.sv
// Bench joining processor end and agent end through the interface.
// Assumes one 40 MHz clock; expectations come from bench functions.
`timescale 1ns/10ps
module processor_system_bus_interface_test
    import sbi_pkg::*;
;
    // Drivers and observed outputs
    logic             clock, rst, cfg_ecc, req_valid, wdata_valid, can_read, can_write;
    logic             reply_valid, reply_last, own_req, req_ready, wdata_ready;
    logic             rdata_valid, rdata_last, rdata_err, ext_cmd_valid, preq_valid;
    logic             pwdata_valid, own_done;
    logic [3:0]       cfg_rate, req_size;
    logic [2:0]       req_type;
    logic [1:0]       rdata_state;
    logic [7:0]       own_cmd;
    logic [CMD_W-1:0] ext_cmd, preq_cmd;
    logic [AD_W-1:0]  req_addr, wdata, reply_data, own_addr, rdata, ext_addr, preq_addr, pwdata;
    logic [AD_W+1:0]  rq[$], eq[$];
    logic [AD_W-1:0]  pq[$], wq[$];
    logic             seen[4];
    int               errors, checks_done, seed;
    sbi_size_e        sizes[6] = '{SBI_SZ_BYTE, SBI_SZ_HALF, SBI_SZ_TRI, SBI_SZ_WORD,
                                   SBI_SZ_DWORD, SBI_SZ_BLOCK};
    sbi_type_e        types[6] = '{SBI_READ, SBI_WRITE, SBI_INVAL, SBI_UPDATE,
                                   SBI_SNOOP, SBI_NULL};

    sbi_if sbi_if_inst ();
    sbi_proc_end #(.WORDS(WBUF_DEPTH)) sbi_proc_end_inst (
        .clock(clock), .rst(rst), .cfg_rate(cfg_rate), .cfg_ecc(cfg_ecc),
        .req_valid(req_valid), .req_ready(req_ready), .req_type(req_type),
        .req_size(req_size), .req_addr(req_addr), .wdata_valid(wdata_valid),
        .wdata_ready(wdata_ready), .wdata(wdata), .rdata_valid(rdata_valid),
        .rdata(rdata), .rdata_last(rdata_last), .rdata_state(rdata_state),
        .rdata_err(rdata_err), .ext_cmd_valid(ext_cmd_valid), .ext_cmd(ext_cmd),
        .ext_addr(ext_addr), .bus(sbi_if_inst));
    sbi_agent_end #(.WORDS(WBUF_DEPTH)) sbi_agent_end_inst (
        .clock(clock), .rst(rst), .can_read(can_read), .can_write(can_write),
        .preq_valid(preq_valid), .preq_cmd(preq_cmd), .preq_addr(preq_addr),
        .pwdata_valid(pwdata_valid), .pwdata(pwdata), .reply_valid(reply_valid),
        .reply_data(reply_data), .reply_last(reply_last), .own_req(own_req),
        .own_cmd(own_cmd), .own_addr(own_addr), .own_done(own_done), .bus(sbi_if_inst));
    sbi_assertions sbi_assertions_inst (
        .clock(clock), .rst(rst), .proc_oe(sbi_if_inst.proc_oe),
        .agent_oe(sbi_if_inst.agent_oe), .command_bus(sbi_if_inst.command_bus),
        .read_accept_ready(sbi_if_inst.read_accept_ready),
        .external_bus_request(sbi_if_inst.external_bus_request),
        .bus_release(sbi_if_inst.bus_release),
        .proc_drive_qualifier(sbi_if_inst.proc_drive_qualifier),
        .agent_drive_qualifier(sbi_if_inst.agent_drive_qualifier));

    // Free-running clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // Hang guard, far beyond the planned traffic
    initial begin
        #(25 * 30000);
        errors++;
        report_and_stop();
    end
    // Pulses caught at the sampling edge, before that edge's updates land
    always @(posedge clock) begin
        if (rdata_valid === 1'b1)
            rq.push_back({rdata_err, rdata_last, rdata});
        if (pwdata_valid === 1'b1)
            pq.push_back(pwdata);
        seen[0] = seen[0] | (preq_valid === 1'b1);
        seen[1] = seen[1] | (ext_cmd_valid === 1'b1);
        seen[2] = seen[2] | (sbi_if_inst.bus_release === 1'b1);
        seen[3] = seen[3] | (own_done === 1'b1);
    end

    // Command word with even parity on top
    function automatic logic [CMD_W-1:0] exp_cmd(input logic [7:0] b);
        return {^b, b};
    endfunction : exp_cmd

    task automatic check(input string what, input logic [AD_W+1:0] seen_v, exp_v);
        checks_done++;
        if (seen_v !== exp_v) begin
            errors++;
            $display("[ERR] %s exp %h seen %h", what, exp_v, seen_v);
        end
    endtask : check

    task automatic wait_flag(input int i);
        int k;
        for (k = 0; k < 400 && seen[i] !== 1'b1; k++)
            @(negedge clock);
        check("handshake", seen[i], 1'b1);
        seen[i] = 1'b0;
    endtask : wait_flag

    // Back to idle master, plus the one-cycle inbound lag
    task automatic wait_idle();
        int k;
        for (k = 0; k < 100 && sbi_if_inst.bus_release !== 1'b0; k++)
            @(negedge clock);
        check("idle", sbi_if_inst.bus_release, 1'b0);
        @(negedge clock);
        seen[2] = 1'b0;
    endtask : wait_idle

    task automatic issue(input logic [2:0] t, input logic [3:0] sz, input logic [AD_W-1:0] a);
        int k;
        req_valid = 1'b1;
        req_type = t;
        req_size = sz;
        req_addr = a;
        for (k = 0; k < 100 && req_ready !== 1'b1; k++)
            @(negedge clock);
        @(negedge clock);
        req_valid = 1'b0;
        check(t == SBI_READ ? "rd held" : "wr held", rq.size() + pq.size(), 0);
        repeat (8) @(negedge clock);
    endtask : issue

    task automatic do_read(input logic [3:0] sz, input logic hold);
        logic [AD_W-1:0] a;
        int w, j;
        a = {$random(seed), $random(seed)};
        w = 1 + ($random(seed) & 3);
        can_read = !hold;
        issue(SBI_READ, sz, a);
        check("release", sbi_if_inst.bus_release, !hold);
        can_read = 1'b1;
        wait_flag(0);
        check("rd command", preq_cmd, exp_cmd({1'b0, SBI_READ, sz}));
        check("rd address", preq_addr, a);
        wait_flag(2);
        j = 0;
        // Agent picks its own pace, with idle gaps
        while (j < w) begin
            reply_valid = 1'($random(seed));
            reply_data = {$random(seed), $random(seed)};
            reply_last = (j == w - 1);
            if (reply_valid)
                eq.push_back({1'b0, reply_last, reply_data});
            j += reply_valid;
            @(negedge clock);
        end
        reply_valid = 1'b0;
        wait_idle();
        check("rd words", rq.size(), eq.size());
        check("rd state", rdata_state, SBI_ST_CLEAN_X);
        while (eq.size() > 0 && rq.size() > 0)
            check("rd word", rq.pop_front(), eq.pop_front());
        rq.delete();
        eq.delete();
    endtask : do_read

    task automatic do_write(input logic [3:0] sz, input int cnt);
        logic [AD_W-1:0] a;
        int k;
        a = {$random(seed), $random(seed)};
        wdata_valid = 1'b1;
        // Fill the line buffer until it refuses or the count is met
        for (k = 0; k < cnt && wdata_ready === 1'b1; k++) begin
            wdata = {$random(seed), $random(seed)};
            wq.push_back(wdata);
            @(negedge clock);
        end
        wdata_valid = 1'b0;
        check("line fill", k, cnt > WBUF_DEPTH ? WBUF_DEPTH : cnt);
        can_write = 1'b0;
        issue(SBI_WRITE, sz, a);
        can_write = 1'b1;
        wait_flag(0);
        check("wr command", preq_cmd, exp_cmd({1'b0, SBI_WRITE, sz}));
        for (k = 0; k < 200 && pq.size() < wq.size(); k++)
            @(negedge clock);
        while (wq.size() > 0 && pq.size() > 0)
            check("wr word", pq.pop_front(), wq.pop_front());
        check("wr extra", pq.size() + wq.size(), 0);
        wait_idle();
    endtask : do_write

    task automatic report_and_stop();
        $display("checks_done %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    // Reset, reads of every size, writes, then every agent request kind
    initial begin
        int k;
        seed = 6334;
        {req_valid, wdata_valid, reply_valid, reply_last, own_req} = '0;
        {req_type, req_size, req_addr, wdata, reply_data, own_addr, own_cmd} = '0;
        {can_read, can_write} = 2'h3;
        seen = '{default: 1'b0};
        cfg_rate = 4'h2;
        cfg_ecc = 1'($random(seed));
        rst = 1'b1;
        repeat (6) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        check("idle release", sbi_if_inst.bus_release, 1'b0);
        check("idle owner", sbi_if_inst.proc_oe, 1'b1);
        for (k = 0; k < 12; k++)
            do_read(sizes[k % 6], k % 4 == 0);
        do_write(SBI_SZ_BLOCK, 20);
        do_write(SBI_SZ_DWORD, 1);
        do_write(SBI_SZ_BYTE, 1);
        foreach (types[i]) begin
            own_cmd = {1'b0, types[i], SBI_SZ_DWORD};
            own_addr = {$random(seed), $random(seed)};
            own_req = 1'b1;
            for (k = 0; k < 50 && sbi_if_inst.external_bus_request !== 1'b1; k++)
                @(negedge clock);
            check("busy refuse", req_ready, 1'b0);
            wait_flag(3);
            own_req = 1'b0;
            wait_flag(1);
            check("ext command", ext_cmd, exp_cmd(own_cmd));
            check("ext address", ext_addr, own_addr);
            wait_idle();
        end
        report_and_stop();
    end
endmodule : processor_system_bus_interface_test
